// *** hdl/port_ctrl_pkg.sv ***
package port_ctrl_pkg;
   // port widths
   localparam int P9_W = 5;
   localparam int PB_W = 6;
   // byte address width, bits
   localparam int ADDR_W = 16;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_PB_LATCH = 16'h000B;
   localparam logic [15:0] IDX_P9_RDBK = 16'h0016;
   localparam logic [15:0] IDX_PB_RDBK = 16'h0018;
   localparam logic [15:0] IDX_PB_DIR = 16'h0F25;
   localparam logic [15:0] IDX_P9_PU = 16'h0F30;
   localparam logic [15:0] IDX_P9_FSEL = 16'h0F3D;
   localparam logic [15:0] IDX_PB_FSEL = 16'h0F3F;
   localparam logic [15:0] IDX_P9_DRV = 16'h0F4A;
   localparam logic [15:0] IDX_PB_DRV = 16'h0F4C;
   // reset values
   localparam logic [7:0] RST_PB_LATCH = 8'h00;
   localparam logic [7:0] RST_PB_DIR = 8'h00;
   localparam logic [7:0] RST_PB_DRV = 8'h00;
   localparam logic [1:0] RST_PB_FSEL = 2'h0;
   localparam logic [4:0] RST_P9 = 5'h00;
   // field position of the uart bits in the port b function select
   localparam int PB_FSEL_LSB = 4;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/port_pin_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
// per-bit pad control for one port, pad outputs registered, readback live
module port_pin_cell #(
   parameter int W = 5
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // per-bit configuration
   input wire logic [W-1:0] dir,
   input wire logic [W-1:0] latch,
   input wire logic [W-1:0] fsel,
   input wire logic [W-1:0] alt,
   input wire logic [W-1:0] open_drain,
   input wire logic [W-1:0] pullup_req,
   // pad side
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out_ff,
   output logic [W-1:0] pin_oe_ff,
   output logic [W-1:0] pullup_on_ff,
   // live readback value
   output logic [W-1:0] readback
);
   // value that would go to the pad
   logic [W-1:0] drive_val;
   // the latch and readback logic cannot serve more than a byte
   if (W < 1 || W > 8) begin : g_chk
      $error("port_pin_cell: W must be 1 to 8");
   end
   assign drive_val = (fsel & alt) | (~fsel & latch);
   assign readback = pin_in & (~dir | open_drain);
   // pad drivers; open drain only ever pulls low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
      end else begin
         pin_out_ff <= drive_val & ~open_drain;
         pin_oe_ff <= dir & (~open_drain | ~drive_val);
      end
   end
   // pull-up only in input mode or open drain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_on_ff <= '0;
      end else begin
         pullup_on_ff <= pullup_req & (~dir | open_drain);
      end
   end
endmodule // port_pin_cell
`default_nettype wire

// *** hdl/axil_reg_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// axi4-lite front end; one write and one read in flight at most
module axil_reg_slave #(
   parameter int AW = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register file side
   output logic wr_stb,
   output logic [AW-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_stb,
   output logic [AW-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   // held halves of a write
   logic aw_held_ff;
   logic w_held_ff;
   // response flops
   logic bvalid_ff;
   logic rvalid_ff;
   // address and data may arrive in either order
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign wr_stb = aw_held_ff && w_held_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   // reads are answered from a register one edge after the take
   assign s_axi_arready = !rvalid_ff;
   assign rd_stb = s_axi_arvalid && !rvalid_ff;
   assign rd_addr = s_axi_araddr;
   assign s_axi_rvalid = rvalid_ff;
   // write channel capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (wr_stb) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
      end
   end
   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         s_axi_bresp <= port_ctrl_pkg::RESP_OKAY;
      end else if (wr_stb) begin
         bvalid_ff <= 1'b1;
         s_axi_bresp <= wr_ok ? port_ctrl_pkg::RESP_OKAY
                              : port_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   // read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= port_ctrl_pkg::RESP_OKAY;
      end else if (rd_stb) begin
         rvalid_ff <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_ok ? port_ctrl_pkg::RESP_OKAY
                              : port_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
endmodule // axil_reg_slave
`default_nettype wire

// *** hdl/port9_portb_gpio_control.sv ***
// Functional notes
// - port9 function select routes secondary output
// - port9 drive type: cmos or open drain
// - port9 pull-up only input or open drain
// - port9 readback: pin unless cmos output
// - port b bits individually input or output
// - port b per-bit open drain or cmos
// - port b latch drives outputs, resets zero
// - port b direction; uart receive/transmit bits
// - port b function select bits 5:4 only
// - port b drive type register, bits 5:0
// - port b readback: pin unless cmos output
`timescale 1ns/1ps
`default_nettype none
module port9_portb_gpio_control (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [port_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [port_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // port 9 state kept by the neighbouring latch block
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_direction,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_output_latch,
   // port 9 secondary outputs, one per bit, from serial units
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_secondary_out,
   // port 9 pads
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_pin_in,
   output logic [port_ctrl_pkg::P9_W-1:0] port9_pin_out,
   output logic [port_ctrl_pkg::P9_W-1:0] port9_pin_oe,
   output logic [port_ctrl_pkg::P9_W-1:0] port9_pullup_on,
   // uart zero transmit, routed to port b bits 5 and 4
   input wire logic uart_zero_transmit_out,
   // uart zero receive feed: bit 0 from pin 4, bit 1 from pin 5
   output logic [1:0] uart_zero_receive_in,
   // port b pads
   input wire logic [port_ctrl_pkg::PB_W-1:0] portb_pin_in,
   output logic [port_ctrl_pkg::PB_W-1:0] portb_pin_out,
   output logic [port_ctrl_pkg::PB_W-1:0] portb_pin_oe
);
   localparam int P9W = port_ctrl_pkg::P9_W;
   localparam int PBW = port_ctrl_pkg::PB_W;
   localparam int AW = port_ctrl_pkg::ADDR_W;
   localparam int FL = port_ctrl_pkg::PB_FSEL_LSB;

   // true when a byte address lands on the given register index
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [15:0] idx);
      hit = (a == {idx[AW-3:0], 2'b00});
   endfunction

   // port b register state
   logic [7:0] portb_output_latch_ff; // full byte, upper two kept
   logic [7:0] portb_direction_ff;    // full byte, upper two set by sw
   logic [7:0] portb_drive_type_ff;   // full byte, upper two stored as written
   logic [1:0] portb_function_select_ff; // uart bits only
   // port 9 register state
   logic [P9W-1:0] port9_pullup_enable_ff;
   logic [P9W-1:0] port9_function_select_ff;
   logic [P9W-1:0] port9_drive_type_ff;

   // register file strobes from the bus front end
   logic wr_stb;
   logic [AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic rd_stb;
   logic [AW-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   // a byte write only lands when lane 0 is enabled
   logic wr_lane0;
   logic [7:0] wr_byte;

   // live readback from each pad group
   logic [P9W-1:0] p9_readback;
   logic [PBW-1:0] pb_readback;
   // port b function select spread over all six bits
   logic [PBW-1:0] pb_fsel_full;
   // port b secondary outputs spread over all six bits
   logic [PBW-1:0] pb_alt;

   assign wr_lane0 = wr_stb && wr_strb[0];
   assign wr_byte = wr_data[7:0];

   // bus slave
   axil_reg_slave #(
      .AW(AW)
   ) u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_stb(rd_stb),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // any mapped address is accepted; readback registers ignore writes
   always_comb begin
      wr_ok = hit(wr_addr, port_ctrl_pkg::IDX_PB_LATCH)
           || hit(wr_addr, port_ctrl_pkg::IDX_P9_RDBK)
           || hit(wr_addr, port_ctrl_pkg::IDX_PB_RDBK)
           || hit(wr_addr, port_ctrl_pkg::IDX_PB_DIR)
           || hit(wr_addr, port_ctrl_pkg::IDX_P9_PU)
           || hit(wr_addr, port_ctrl_pkg::IDX_P9_FSEL)
           || hit(wr_addr, port_ctrl_pkg::IDX_PB_FSEL)
           || hit(wr_addr, port_ctrl_pkg::IDX_P9_DRV)
           || hit(wr_addr, port_ctrl_pkg::IDX_PB_DRV);
   end

   // port b output latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portb_output_latch_ff <= port_ctrl_pkg::RST_PB_LATCH;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_PB_LATCH)) begin
         // upper two bits stored as written; software keeps them zero
         portb_output_latch_ff <= wr_byte;
      end
   end

   // port b direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portb_direction_ff <= port_ctrl_pkg::RST_PB_DIR;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_PB_DIR)) begin
         portb_direction_ff <= wr_byte;
      end
   end

   // port b drive type
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portb_drive_type_ff <= port_ctrl_pkg::RST_PB_DRV;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_PB_DRV)) begin
         portb_drive_type_ff <= wr_byte;
      end
   end

   // port b function select, only the uart bits hold state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         portb_function_select_ff <= port_ctrl_pkg::RST_PB_FSEL;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_PB_FSEL)) begin
         portb_function_select_ff <= wr_byte[FL+1:FL];
      end
   end

   // port 9 pull-up enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port9_pullup_enable_ff <= port_ctrl_pkg::RST_P9;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_P9_PU)) begin
         port9_pullup_enable_ff <= wr_byte[P9W-1:0];
      end
   end

   // port 9 function select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port9_function_select_ff <= port_ctrl_pkg::RST_P9;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_P9_FSEL)) begin
         port9_function_select_ff <= wr_byte[P9W-1:0];
      end
   end

   // port 9 drive type
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port9_drive_type_ff <= port_ctrl_pkg::RST_P9;
      end else if (wr_lane0 && hit(wr_addr, port_ctrl_pkg::IDX_P9_DRV)) begin
         port9_drive_type_ff <= wr_byte[P9W-1:0];
      end
   end

   // read mux; readbacks are sampled live at the read take
   always_comb begin
      rd_data = '0;
      rd_ok = 1'b1;
      if (hit(rd_addr, port_ctrl_pkg::IDX_PB_LATCH)) begin
         rd_data[7:0] = portb_output_latch_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_P9_RDBK)) begin
         rd_data[P9W-1:0] = p9_readback;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_PB_RDBK)) begin
         rd_data[PBW-1:0] = pb_readback;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_PB_DIR)) begin
         rd_data[7:0] = portb_direction_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_P9_PU)) begin
         rd_data[P9W-1:0] = port9_pullup_enable_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_P9_FSEL)) begin
         rd_data[P9W-1:0] = port9_function_select_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_PB_FSEL)) begin
         rd_data[FL+1:FL] = portb_function_select_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_P9_DRV)) begin
         rd_data[P9W-1:0] = port9_drive_type_ff;
      end else if (hit(rd_addr, port_ctrl_pkg::IDX_PB_DRV)) begin
         rd_data[7:0] = portb_drive_type_ff;
      end else begin
         // unmapped: zero data with an error response
         rd_ok = 1'b0;
      end
   end

   // port b secondary routing; only bits 5:4 carry the uart
   always_comb begin
      pb_fsel_full = '0;
      pb_alt = '0;
      pb_fsel_full[FL+1:FL] = portb_function_select_ff;
      pb_alt[FL+1:FL] = {2{uart_zero_transmit_out}};
   end

   // port 9 pads
   port_pin_cell #(
      .W(P9W)
   ) u_p9 (
      .aclk(aclk),
      .aresetn(aresetn),
      .dir(port9_direction),
      .latch(port9_output_latch),
      .fsel(port9_function_select_ff),
      .alt(port9_secondary_out),
      .open_drain(port9_drive_type_ff),
      .pullup_req(port9_pullup_enable_ff),
      .pin_in(port9_pin_in),
      .pin_out_ff(port9_pin_out),
      .pin_oe_ff(port9_pin_oe),
      .pullup_on_ff(port9_pullup_on),
      .readback(p9_readback)
   );

   // port b pads; this port has no pull-up
   port_pin_cell #(
      .W(PBW)
   ) u_pb (
      .aclk(aclk),
      .aresetn(aresetn),
      .dir(portb_direction_ff[PBW-1:0]),
      .latch(portb_output_latch_ff[PBW-1:0]),
      .fsel(pb_fsel_full),
      .alt(pb_alt),
      .open_drain(portb_drive_type_ff[PBW-1:0]),
      .pullup_req({PBW{1'b0}}),
      .pin_in(portb_pin_in),
      .pin_out_ff(portb_pin_out),
      .pin_oe_ff(portb_pin_oe),
      .pullup_on_ff(),
      .readback(pb_readback)
   );

   // uart receive feed; an output-mode pin gives idle high so the
   // receiver does not see a false start bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         uart_zero_receive_in <= 2'h3;
      end else begin
         uart_zero_receive_in <= portb_pin_in[FL+1:FL]
                               | portb_direction_ff[FL+1:FL];
      end
   end
endmodule // port9_portb_gpio_control
`default_nettype wire

// *** tb/gpio_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the gpio control block
module gpio_ctrl_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus read and response side
   input wire logic [port_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // port 9
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_direction,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_output_latch,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_secondary_out,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_pin_out,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_pin_oe,
   input wire logic [port_ctrl_pkg::P9_W-1:0] port9_pullup_on,
   // port b and uart feed
   input wire logic [1:0] uart_zero_receive_in,
   input wire logic [port_ctrl_pkg::PB_W-1:0] portb_pin_out,
   input wire logic [port_ctrl_pkg::PB_W-1:0] portb_pin_oe
);
   // byte address of the port 9 readback word
   localparam logic [15:0] P9_RD_ADDR =
      {port_ctrl_pkg::IDX_P9_RDBK[13:0], 2'h0};
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read lanes set");
   p9_top_zero_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == P9_RD_ADDR
      |=> s_axi_rdata[7:5] == 3'h0) else $error("port 9 top bits set");
   p9_oe_dir_a: assert property (
      (port9_pin_oe & ~$past(port9_direction)) == 5'h00)
      else $error("port 9 drives an input");
   p9_pu_cmos_a: assert property (
      (port9_pullup_on & port9_pin_oe & port9_pin_out) == 5'h00)
      else $error("pull-up on driven high pin");
   p9_value_a: assert property (
      (port9_pin_out & port9_pin_oe
      & ~$past(port9_secondary_out | port9_output_latch)) == 5'h00)
      else $error("port 9 high without source");
   rx_out_a: assert property (
      (portb_pin_oe[5:4] & ~uart_zero_receive_in) == 2'h0)
      else $error("receive feed low on output");
   rst_idle_a: assert property ($rose(aresetn)
      |-> portb_pin_oe == 6'h00 && portb_pin_out == 6'h00)
      else $error("port b active after reset");
   // main scenarios seen
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (port9_pullup_on == 5'h1F);
endmodule // gpio_ctrl_checker

bind port9_portb_gpio_control gpio_ctrl_checker chk (.*);
`default_nettype wire

// *** tb/pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// package pins: resolves each pad from all drivers
module pin_partner (
   // clock
   input wire logic aclk,
   // port 9 pads
   input wire logic [4:0] port9_pin_out,
   input wire logic [4:0] port9_pin_oe,
   input wire logic [4:0] port9_pullup_on,
   input wire logic [4:0] port9_ext,
   input wire logic port9_ext_en,
   output logic [4:0] port9_pin_in,
   // port b pads
   input wire logic [5:0] portb_pin_out,
   input wire logic [5:0] portb_pin_oe,
   input wire logic [5:0] portb_ext,
   input wire logic portb_ext_en,
   output logic [5:0] portb_pin_in
);
   logic [5:0] float_ff = 6'h15;
   // an undriven pad without pull-up never reads a stable value
   always_ff @(posedge aclk) begin
      float_ff <= ~float_ff;
   end
   assign port9_pin_in = port9_pin_oe & port9_pin_out
      | ~port9_pin_oe & (port9_ext_en ? port9_ext
      : port9_pullup_on | float_ff[4:0]);
   // no pull-up on port b
   assign portb_pin_in = portb_pin_oe & portb_pin_out
      | ~portb_pin_oe & (portb_ext_en ? portb_ext : float_ff);
endmodule // pin_partner
`default_nettype wire

// *** tb/test_port9_portb_gpio_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_port9_portb_gpio_control;
   // one table step: write or read, value, response
   typedef struct packed {
      logic wr;
      logic [15:0] idx;
      logic [7:0] val;
      logic [1:0] resp;
   } row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   // bus master side
   logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // port 9 neighbours and pads
   logic [4:0] port9_direction = 5'h00, port9_output_latch = 5'h00;
   logic [4:0] port9_secondary_out = 5'h00, port9_ext = 5'h15;
   logic port9_ext_en = 1'b1;
   logic [4:0] port9_pin_in, port9_pin_out, port9_pin_oe, port9_pullup_on;
   // port b and uart
   logic uart_zero_transmit_out = 1'b0;
   logic [1:0] uart_zero_receive_in;
   logic [5:0] portb_pin_in, portb_pin_out, portb_pin_oe;
   int failures = 0;
   int checked = 0;
   logic [31:0] data;
   logic [1:0] resp;
   // short names for the register indices
   localparam logic [15:0] LAT = port_ctrl_pkg::IDX_PB_LATCH,
      RD9 = port_ctrl_pkg::IDX_P9_RDBK,
      RDB = port_ctrl_pkg::IDX_PB_RDBK,
      DIR = port_ctrl_pkg::IDX_PB_DIR,
      PU9 = port_ctrl_pkg::IDX_P9_PU,
      FS9 = port_ctrl_pkg::IDX_P9_FSEL,
      FSB = port_ctrl_pkg::IDX_PB_FSEL,
      DR9 = port_ctrl_pkg::IDX_P9_DRV,
      DRB = port_ctrl_pkg::IDX_PB_DRV;
   // register walk
   row_t rows [28] = '{
      '{1'b0, FS9, 8'h00, 2'h0},
      '{1'b0, DR9, 8'h00, 2'h0},
      '{1'b0, PU9, 8'h00, 2'h0},
      '{1'b0, FSB, 8'h00, 2'h0},
      '{1'b0, DRB, 8'h00, 2'h0},
      '{1'b0, DIR, 8'h00, 2'h0},
      '{1'b0, LAT, 8'h00, 2'h0},
      '{1'b0, RD9, 8'h15, 2'h0},
      '{1'b0, RDB, 8'h2A, 2'h0},
      '{1'b1, DIR, 8'hCF, 2'h0},
      '{1'b0, DIR, 8'hCF, 2'h0},
      '{1'b1, LAT, 8'h07, 2'h0},
      '{1'b0, LAT, 8'h07, 2'h0},
      '{1'b1, DRB, 8'h02, 2'h0},
      '{1'b0, DRB, 8'h02, 2'h0},
      '{1'b0, RDB, 8'h22, 2'h0},
      '{1'b1, FSB, 8'hFF, 2'h0},
      '{1'b0, FSB, 8'h30, 2'h0},
      '{1'b1, RD9, 8'hFF, 2'h0},
      '{1'b0, RD9, 8'h15, 2'h0},
      '{1'b1, 16'h0100, 8'h55, 2'h2},
      '{1'b0, 16'h0100, 8'h00, 2'h2},
      '{1'b1, PU9, 8'hFF, 2'h0},
      '{1'b0, PU9, 8'h1F, 2'h0},
      '{1'b1, FS9, 8'hFF, 2'h0},
      '{1'b0, FS9, 8'h1F, 2'h0},
      '{1'b1, DR9, 8'hFF, 2'h0},
      '{1'b0, DR9, 8'h1F, 2'h0}};

   port9_portb_gpio_control DUT (.*);
   pin_partner pads (.aclk, .port9_pin_out, .port9_pin_oe, .port9_pullup_on,
      .port9_ext, .port9_ext_en, .port9_pin_in, .portb_pin_out,
      .portb_pin_oe, .portb_ext(6'h2A), .portb_ext_en(1'b1), .portb_pin_in);

   // 40 MHz clock
   initial begin
      forever #12.5 aclk = ~aclk;
   end

   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task stop_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // a wait that runs out ends the run
   task limit(input int n);
      if (n > 50) begin
         check("wait cycles", 32'h0, 32'h1);
         stop_test();
      end
   endtask

   // each half held until its own ready edge; bresp taken at bready edge
   task wr(input logic [15:0] idx, input logic [7:0] d,
           output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= idx << 2;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
         limit(n);
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // address held until arready edge; data taken at the rready edge
   task rd(input logic [15:0] idx, output logic [31:0] d,
           output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= idx << 2;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
         limit(n);
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // pins settle one edge after their cause
   task settle;
      repeat (2) @(posedge aclk);
      #1;
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].idx, rows[i].val, resp);
         end else begin
            rd(rows[i].idx, data, resp);
            check("read data", data, {24'h0, rows[i].val});
         end
         check("response", resp, rows[i].resp);
      end
      // port b: outputs 0 and 2 high, 3 low, open drain released, uart pins input
      settle();
      check("portb oe", portb_pin_oe, 6'h0D);
      check("portb out", portb_pin_out & portb_pin_oe, 6'h05);
      check("uart rx", uart_zero_receive_in, 2'h2);
      wr(DIR, 8'hFF, resp);
      uart_zero_transmit_out <= 1'b1;
      settle();
      check("portb tx high", portb_pin_out & portb_pin_oe, 6'h35);
      check("uart rx out", uart_zero_receive_in, 2'h3);
      uart_zero_transmit_out <= 1'b0;
      settle();
      check("portb tx low", portb_pin_out & portb_pin_oe, 6'h05);
      // port 9 open drain on serial outputs, pads pulled up
      port9_direction <= 5'h1F;
      port9_output_latch <= 5'h0A;
      port9_secondary_out <= 5'h11;
      port9_ext_en <= 1'b0;
      settle();
      check("p9 oe od", port9_pin_oe, 5'h0E);
      check("p9 out od", port9_pin_out, 5'h00);
      check("p9 pullup od", port9_pullup_on, 5'h1F);
      rd(RD9, data, resp);
      check("p9 readback od", data, 32'h11);
      wr(DR9, 8'h00, resp);
      settle();
      check("p9 oe cmos", port9_pin_oe, 5'h1F);
      check("p9 out cmos", port9_pin_out, 5'h11);
      check("p9 pullup cmos", port9_pullup_on, 5'h00);
      rd(RD9, data, resp);
      check("p9 readback cmos", data, 32'h00);
      wr(FS9, 8'h00, resp);
      settle();
      check("p9 out latch", port9_pin_out, 5'h0A);
      // reset in mid-run clears port b
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      check("portb oe reset", portb_pin_oe, 6'h00);
      rd(LAT, data, resp);
      check("latch reset", data, 32'h00);
      stop_test();
   end
endmodule // test_port9_portb_gpio_control
`default_nettype wire
